// *** core/pin_sync.sv ***
// Purpose: three-stage synchroniser with agreement filter for all pins
// Assumes: pins are asynchronous to clock
// Notes:   a change counts once the second and third stages agree
`timescale 1ns/1ps
`default_nettype none

module pin_sync
(
  input wire logic clock,
  input wire logic srst,
  input wire sg_pkg::pins_t rawPins,
  output var sg_pkg::pins_t stablePins
);

  sg_pkg::syncState_t st_r;
  sg_pkg::syncState_t st_nxt;

  // ********************************************************************
  // next state
  // ********************************************************************
  // shift chain, filter follows only when stages two and three agree
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.s1 = rawPins;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    st_nxt.filt = ((st_r.s2 ~^ st_r.s3) & st_r.s2) | ((st_r.s2 ^ st_r.s3) & st_r.filt);
  end

  // idle level of every pin is high
  always_ff @(posedge clock)
  begin
    if (srst)
      st_r <= '1;
    else
      st_r <= st_nxt;
  end

  assign stablePins = st_r.filt;

endmodule : pin_sync

`default_nettype wire

// *** core/sensor_gate_field_sequencer.sv ***
// Purpose: sensor gate pulse outputs and field sequencing
// Assumes: serial write port, sync pins active low, pixel clock domain
// Notes:   outputs are registered; field settings follow the live field
//
// Behaviour
// R1: five outputs, each picks one of four patterns
// R2: pattern starts at level, inverts at two positions
// R3: pulses only on the field's selected lines
// R4: second line selector repeats pulses on another line
// R5: each output individually maskable
// R6: mask bit zero is output one, bit four output five
// R7: two select bits per output, output one lowest
// R8: select, mask, lines held per field, follow field
// R9: six fields of stored timing
// R10: top three mode bits give field count
// R11: seven 3-bit slots hold field numbers
// R12: run first slot, advance on each vertical sync
// R13: after count fields, wrap to first slot
// R14: new mode takes effect at next vertical sync
// R15: masked or inactive output holds its start level
`timescale 1ns/1ps
`default_nettype none
`include "sg_cfg.svh"

module sensor_gate_field_sequencer
(
  input wire logic clock,
  input wire logic srst,
  input wire logic horizontalSyncN,
  input wire logic verticalSyncN,
  input wire logic serClk,
  input wire logic serData,
  input wire logic serLoadN,
  output logic [`GATE_COUNT-1:0] sensorGateOutputs,
  output logic [`SLOT_WIDTH-1:0] activeField
);

  sg_pkg::seqState_t st_r;
  sg_pkg::seqState_t st_nxt;
  sg_pkg::pins_t rawPins;
  sg_pkg::pins_t stablePins;
  sg_pkg::regWrite_t wr;
  logic wrValid;
  logic hsEdge;
  logic vsEdge;
  logic lineHit;
  logic [`SLOT_WIDTH-1:0] seqCount;
  logic [`SLOT_WIDTH-1:0] slotCode;
  logic [`SEL_WIDTH-1:0] curSel;
  logic [`GATE_COUNT-1:0] curMask;
  logic [`GATE_COUNT-1:0] startSel;
  logic [`GATE_COUNT-1:0] hit1;
  logic [`GATE_COUNT-1:0] hit2;
  logic [`GATE_COUNT-1:0] gateNxt;

  // ********************************************************************
  // pin synchronisers and serial port
  // ********************************************************************
  assign rawPins = '{horizontalSyncN, verticalSyncN, serClk, serData, serLoadN};

  pin_sync u_sync
  (
    .clock(clock),
    .srst(srst),
    .rawPins(rawPins),
    .stablePins(stablePins)
  );

  serial_reg_loader u_loader
  (
    .clock(clock),
    .srst(srst),
    .serClk(stablePins.serClk),
    .serData(stablePins.serData),
    .serLoadN(stablePins.serLoadN),
    .wr(wr),
    .wrValid(wrValid)
  );

  // ********************************************************************
  // field decode
  // ********************************************************************
  // falling edges of the filtered sync levels
  assign hsEdge = st_r.hsPrev && !stablePins.horizontalSyncN;
  assign vsEdge = st_r.vsPrev && !stablePins.verticalSyncN;
  // R10: field count
  assign seqCount = st_r.activeSeq[`SEQ_WIDTH-1:`SEQ_COUNT_LSB];
  // R11: slot code of current slot
  assign slotCode = st_r.activeSeq[5'(st_r.slot) * 5'd3 +: 3];
  // R8: settings of the live field
  assign curSel = st_r.patternSelect[st_r.curField];
  assign curMask = st_r.outputMask[st_r.curField];
  // R3: active line test
  // R4: repeat line
  assign lineHit = (st_r.line == st_r.activeLineA[st_r.curField]) ||
                   (st_r.line == st_r.activeLineB[st_r.curField]);

  // ********************************************************************
  // per output pattern logic
  // ********************************************************************
  generate
    for (genvar i = 0; i < `GATE_COUNT; i++)
    begin : g_gate
      logic [1:0] pat;
      // R1: pattern choice
      // R7: two bits per output
      assign pat = curSel[2*i +: 2];
      assign startSel[i] = st_r.startLevel[pat];
      // R2: invert at first then second position
      assign hit1[i] = st_r.pixel >= st_r.firstToggle[pat];
      assign hit2[i] = hit1[i] && (st_r.pixel >= st_r.secondToggle[pat]);
      // R5: per output mask
      // R15: held start level
      assign gateNxt[i] = startSel[i] ^ ((lineHit && !curMask[i]) & (hit1[i] ^ hit2[i]));
    end
  endgenerate

  // ********************************************************************
  // next state
  // ********************************************************************
  always_comb
  begin
    logic [2:0] fIdx;
    fIdx = 3'h0;
    st_nxt = st_r;
    st_nxt.hsPrev = stablePins.horizontalSyncN;
    st_nxt.vsPrev = stablePins.verticalSyncN;
    st_nxt.gate = gateNxt;
    // pixel and line counters
    if (hsEdge)
    begin
      st_nxt.pixel = '0;
      st_nxt.line = st_r.line + 12'h001;
    end
    else
      st_nxt.pixel = st_r.pixel + 12'h001;
    if (vsEdge)
      st_nxt.line = '0;
    // R12: advance on vertical sync
    if (vsEdge)
    begin
      // R14: pending sequence starts at slot one
      if (st_r.pendingFlag)
      begin
        st_nxt.activeSeq = st_r.pendingSeq;
        st_nxt.slot = '0;
        st_nxt.pendingFlag = 1'b0;
      end
      // R13: wrap after the counted fields
      else if ((st_r.slot + 3'h1) >= seqCount)
        st_nxt.slot = '0;
      else
        st_nxt.slot = st_r.slot + 3'h1;
    end
    // R9: invalid codes keep the previous field
    if (slotCode <= `FIELD_MAX)
      st_nxt.curField = slotCode;
    // register writes; a write beats a same-cycle take of the pending flag
    if (wrValid)
    begin
      if (wr.addr >= `ADDR_PAT_TOG_BASE && wr.addr < `ADDR_PAT_TOG_END)
      begin
        st_nxt.firstToggle[wr.addr[1:0]] = wr.data[11:0];
        st_nxt.secondToggle[wr.addr[1:0]] = wr.data[23:12];
      end
      else if (wr.addr >= `ADDR_PAT_LVL_BASE && wr.addr < `ADDR_PAT_LVL_END)
        st_nxt.startLevel[wr.addr[1:0]] = wr.data[0];
      else if (wr.addr == `ADDR_SEQ_MODE)
      begin
        // R14: held until the next vertical sync
        st_nxt.pendingSeq = wr.data;
        st_nxt.pendingFlag = 1'b1;
      end
      else if (wr.addr >= `ADDR_FIELD_BASE && wr.addr < `ADDR_FIELD_END)
      begin
        // R8: one register set per field
        fIdx = 3'((wr.addr - `ADDR_FIELD_BASE) >> 2);
        if (wr.addr[1:0] == `FIELD_OFS_SEL)
          st_nxt.patternSelect[fIdx] = wr.data[`SEL_WIDTH-1:0];
        else if (wr.addr[1:0] == `FIELD_OFS_MASK)
          // R6: bit per output
          st_nxt.outputMask[fIdx] = wr.data[`GATE_COUNT-1:0];
        else if (wr.addr[1:0] == `FIELD_OFS_LINE_A)
          st_nxt.activeLineA[fIdx] = wr.data[11:0];
        else
          st_nxt.activeLineB[fIdx] = wr.data[11:0];
      end
    end
  end

  // ********************************************************************
  // state register
  // ********************************************************************
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      st_r <= '0;
      st_r.activeSeq <= `MODE_RESET;
      st_r.hsPrev <= 1'b1;
      st_r.vsPrev <= 1'b1;
    end
    else
      st_r <= st_nxt;
  end

  assign sensorGateOutputs = st_r.gate;
  assign activeField = st_r.curField;

  // ********************************************************************
  // assertions
  // ********************************************************************
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (srst);

  property p_seqAdvance;
    vsEdge && !st_r.pendingFlag && ((st_r.slot + 3'h1) < seqCount) |=> st_r.slot == $past(st_r.slot) + 3'h1;
  endproperty
  a_seqAdvance: assert property (p_seqAdvance) else $error("slot did not advance"); // R12

  property p_seqWrap;
    vsEdge && !st_r.pendingFlag && (seqCount != 3'h0) && ((st_r.slot + 3'h1) == seqCount) |=> st_r.slot == 3'h0;
  endproperty
  a_seqWrap: assert property (p_seqWrap) else $error("sequence did not wrap"); // R13

  property p_newSeqAtSync;
    vsEdge && st_r.pendingFlag |=> (st_r.slot == 3'h0) && (st_r.activeSeq == $past(st_r.pendingSeq));
  endproperty
  a_newSeqAtSync: assert property (p_newSeqAtSync) else $error("new mode not taken at sync"); // R14

  property p_noEarlyTake;
    !vsEdge |=> st_r.activeSeq == $past(st_r.activeSeq) && st_r.slot == $past(st_r.slot);
  endproperty
  a_noEarlyTake: assert property (p_noEarlyTake) else $error("sequence changed mid field"); // R14

  property p_inactiveLine;
    !lineHit |=> sensorGateOutputs == $past(startSel);
  endproperty
  a_inactiveLine: assert property (p_inactiveLine) else $error("gate moved off active line"); // R3

  property p_maskHold;
    curMask[4] |=> sensorGateOutputs[4] == $past(startSel[4]);
  endproperty
  a_maskHold: assert property (p_maskHold) else $error("masked output moved"); // R6

  property p_firstToggle;
    lineHit && !curMask[0] && hit1[0] && !hit2[0] |=> sensorGateOutputs[0] != $past(startSel[0]);
  endproperty
  a_firstToggle: assert property (p_firstToggle) else $error("first toggle missed"); // R2

  property p_fieldRange;
    activeField <= `FIELD_MAX;
  endproperty
  a_fieldRange: assert property (p_fieldRange) else $error("field out of range"); // R9

  property p_secondToggle;
    lineHit && !curMask[0] && hit2[0] |=> sensorGateOutputs[0] == $past(startSel[0]);
  endproperty
  a_secondToggle: assert property (p_secondToggle) else $error("second toggle missed"); // R2

  // counter checks
  property p_lineRestart;
    vsEdge |=> st_r.line == 12'h000;
  endproperty
  a_lineRestart: assert property (p_lineRestart) else $error("line count not cleared at field sync"); // R3

  property p_lineStep;
    hsEdge && !vsEdge |=> st_r.line == $past(st_r.line) + 12'h001;
  endproperty
  a_lineStep: assert property (p_lineStep) else $error("line count did not step"); // R4

  // sequence and field checks
  property p_seqCountBound;
    vsEdge && !st_r.pendingFlag && (seqCount != 3'h0) |=> st_r.slot < $past(seqCount);
  endproperty
  a_seqCountBound: assert property (p_seqCountBound) else $error("slot beyond field count"); // R10

  property p_fieldFollow;
    slotCode <= `FIELD_MAX |=> activeField == $past(slotCode);
  endproperty
  a_fieldFollow: assert property (p_fieldFollow) else $error("field does not follow slot"); // R11

  property p_modePending;
    wrValid && (wr.addr == `ADDR_SEQ_MODE) |=> st_r.pendingFlag && (st_r.pendingSeq == $past(wr.data));
  endproperty
  a_modePending: assert property (p_modePending) else $error("mode write not held pending"); // R14

  // output selection checks
  property p_maskFirst;
    curMask[0] |=> sensorGateOutputs[0] == $past(startSel[0]);
  endproperty
  a_maskFirst: assert property (p_maskFirst) else $error("masked first output moved"); // R5

  property p_selectPair;
    !lineHit |=> sensorGateOutputs[1] == $past(st_r.startLevel[curSel[3:2]]);
  endproperty
  a_selectPair: assert property (p_selectPair) else $error("second output used wrong pattern"); // R7

  c_wrap: cover property (vsEdge && !st_r.pendingFlag && seqCount > 3'h1 ##1 st_r.slot == 3'h0);
  c_newSeq: cover property (vsEdge && st_r.pendingFlag);
  c_gatePulse: cover property (lineHit && !curMask[0] && hit1[0] && !hit2[0]);
  c_maskedLine: cover property (lineHit && (curMask != 5'h00));

endmodule : sensor_gate_field_sequencer

`default_nettype wire

// *** core/serial_reg_loader.sv ***
// Purpose: collects one 32-bit serial frame into a register write
// Assumes: inputs already synchronised and filtered
// Notes:   frames of any length other than 32 bits are dropped
`timescale 1ns/1ps
`default_nettype none
`include "sg_cfg.svh"

module serial_reg_loader
(
  input wire logic clock,
  input wire logic srst,
  input wire logic serClk,
  input wire logic serData,
  input wire logic serLoadN,
  output var sg_pkg::regWrite_t wr,
  output logic wrValid
);

  sg_pkg::loaderState_t st_r;
  sg_pkg::loaderState_t st_nxt;

  // ********************************************************************
  // frame capture
  // ********************************************************************
  // shift on rising serial clock while load is low, commit on load release
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.prevClk = serClk;
    st_nxt.prevLoadN = serLoadN;
    st_nxt.wrValid = 1'b0;
    if (serLoadN && !st_r.prevLoadN)
    begin
      if (st_r.count == `FRAME_BITS)
      begin
        st_nxt.wr.addr = st_r.shift[7:0];
        st_nxt.wr.data = st_r.shift[`FRAME_WIDTH-1:8];
        st_nxt.wrValid = 1'b1;
      end
      st_nxt.count = 6'h00;
    end
    else if (!serLoadN && serClk && !st_r.prevClk)
    begin
      st_nxt.shift = {serData, st_r.shift[`FRAME_WIDTH-1:1]};
      if (st_r.count != 6'h3f)
        st_nxt.count = st_r.count + 6'h01;
    end
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      st_r <= '0;
      st_r.prevClk <= 1'b1;
      st_r.prevLoadN <= 1'b1;
    end
    else
      st_r <= st_nxt;
  end

  assign wr = st_r.wr;
  assign wrValid = st_r.wrValid;

endmodule : serial_reg_loader

`default_nettype wire

// *** core/sg_cfg.svh ***
// Purpose: constants for the sensor gate and field sequencer block
// Assumes: included by bare name wherever a constant is needed
// Notes:   serial frame is 8 address bits then 24 data bits, lsb first
`ifndef SG_CFG_SVH
`define SG_CFG_SVH

// ********************************************************************
// register addresses
// ********************************************************************
`define ADDR_PAT_TOG_BASE 8'h00
`define ADDR_PAT_TOG_END 8'h04
`define ADDR_PAT_LVL_BASE 8'h04
`define ADDR_PAT_LVL_END 8'h08
`define ADDR_SEQ_MODE 8'h10
`define ADDR_FIELD_BASE 8'h20
`define ADDR_FIELD_END 8'h38
`define FIELD_OFS_SEL 2'h0
`define FIELD_OFS_MASK 2'h1
`define FIELD_OFS_LINE_A 2'h2
`define FIELD_OFS_LINE_B 2'h3

// ********************************************************************
// field layouts and reset values
// ********************************************************************
`define PIN_COUNT 5
`define GATE_COUNT 5
`define PATTERN_COUNT 4
`define FIELD_COUNT 6
`define POS_WIDTH 12
`define SEQ_WIDTH 24
`define SEL_WIDTH 10
`define SLOT_WIDTH 3
`define SEQ_COUNT_LSB 21
`define FIELD_MAX 3'h5
`define MODE_RESET 24'h200000
`define FRAME_BITS 6'h20
`define FRAME_WIDTH 32

`endif

// *** core/sg_pkg.sv ***
// Purpose: shared types of the sensor gate and field sequencer block
// Assumes: constants come from sg_cfg.svh
// Notes:   every module keeps its whole state in one struct from here
`include "sg_cfg.svh"

package sg_pkg;

  // ********************************************************************
  // pins and register writes
  // ********************************************************************
  typedef struct packed {
    logic horizontalSyncN;
    logic verticalSyncN;
    logic serClk;
    logic serData;
    logic serLoadN;
  } pins_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [`SEQ_WIDTH-1:0] data;
  } regWrite_t;

  // ********************************************************************
  // module states
  // ********************************************************************
  typedef struct packed {
    pins_t s1;
    pins_t s2;
    pins_t s3;
    pins_t filt;
  } syncState_t;

  typedef struct packed {
    logic prevClk;
    logic prevLoadN;
    logic [`FRAME_WIDTH-1:0] shift;
    logic [5:0] count;
    regWrite_t wr;
    logic wrValid;
  } loaderState_t;

  typedef struct packed {
    logic [`PATTERN_COUNT-1:0][`POS_WIDTH-1:0] firstToggle;
    logic [`PATTERN_COUNT-1:0][`POS_WIDTH-1:0] secondToggle;
    logic [`PATTERN_COUNT-1:0] startLevel;
    logic [`FIELD_COUNT-1:0][`SEL_WIDTH-1:0] patternSelect;
    logic [`FIELD_COUNT-1:0][`GATE_COUNT-1:0] outputMask;
    logic [`FIELD_COUNT-1:0][`POS_WIDTH-1:0] activeLineA;
    logic [`FIELD_COUNT-1:0][`POS_WIDTH-1:0] activeLineB;
    logic [`SEQ_WIDTH-1:0] activeSeq;
    logic [`SEQ_WIDTH-1:0] pendingSeq;
    logic pendingFlag;
    logic [`SLOT_WIDTH-1:0] slot;
    logic [`SLOT_WIDTH-1:0] curField;
    logic [`POS_WIDTH-1:0] pixel;
    logic [`POS_WIDTH-1:0] line;
    logic hsPrev;
    logic vsPrev;
    logic [`GATE_COUNT-1:0] gate;
  } seqState_t;

endpackage : sg_pkg

// *** test/sensor_gate_field_sequencer_tb.sv ***
// Purpose: self-checking bench for the sensor gate field sequencer
// Assumes: serial writes only, no read-back; sync pins active low
// Notes:   gates sampled mid-segment so sync latency cannot matter
`timescale 1ns/1ps
`default_nettype none
`include "sg_cfg.svh"

module sensor_gate_field_sequencer_tb;
  logic clock, srst, horizontalSyncN, verticalSyncN, serClk, serData, serLoadN;
  logic [`GATE_COUNT-1:0] sensorGateOutputs;
  logic [`GATE_COUNT-1:0] ccdGate;
  logic [`SLOT_WIDTH-1:0] activeField;
  int n_errors = 0;
  int checks = 0;
  int seed = 32'h6c306150;
  int pT1[4], pT2[4], pLvl[4], fSel[6], fMask[6], fLineA[6], fLineB[6];
  int seqSlots[$], newSlots[$];
  int curSlot = 0;
  int curField = 0;
  bit pending = 0;

  // ********************************************************************
  // design and far side
  // ********************************************************************
  sensor_gate_field_sequencer u_dut
  (
    .clock(clock),
    .srst(srst),
    .horizontalSyncN(horizontalSyncN),
    .verticalSyncN(verticalSyncN),
    .serClk(serClk),
    .serData(serData),
    .serLoadN(serLoadN),
    .sensorGateOutputs(sensorGateOutputs),
    .activeField(activeField)
  );

  vertical_driver_model u_drv
  (
    .gateIn(sensorGateOutputs),
    .ccdGate(ccdGate)
  );

  // 40 mhz pixel clock
  initial
  begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  // ********************************************************************
  // helpers and model
  // ********************************************************************
  task automatic tick(input int n);
    repeat (n) @(negedge clock);
  endtask : tick

  function automatic int rnd(input int n);
    return $unsigned($random(seed)) % n;
  endfunction : rnd

  // model of gate levels for one field, line and pixel
  function automatic logic [4:0] exp_gates(input int f, input int ln, input int px);
    logic [4:0] r;
    int p;
    bit act;
    for (int g = 0; g < 5; g++)
    begin
      p = (fSel[f] >> (2 * g)) & 3;
      act = (ln == fLineA[f] || ln == fLineB[f]) && !fMask[f][g];
      r[g] = pLvl[p][0] ^ (act && px >= pT1[p]) ^ (act && px >= pT2[p]);
    end
    return r;
  endfunction : exp_gates

  task automatic cmp_gates(input logic [4:0] exp);
    checks++;
    if (sensorGateOutputs !== exp || ccdGate !== ~exp)
    begin
      n_errors++;
      $display("[FAIL] %0t gates %b expected %b", $time, sensorGateOutputs, exp);
    end
  endtask : cmp_gates

  task automatic cmp_field(input logic [2:0] exp);
    checks++;
    if (activeField !== exp)
    begin
      n_errors++;
      $display("[FAIL] %0t field %0d expected %0d", $time, activeField, exp);
    end
  endtask : cmp_field

  // one 32-bit frame, lsb first, each level held 4 clocks
  task automatic ser_write(input logic [7:0] addr, input logic [23:0] data);
    logic [31:0] frame;
    frame = {data, addr};
    serLoadN = 1'b0;
    tick(4);
    for (int i = 0; i < 32; i++)
    begin
      serData = frame[i];
      serClk = 1'b0;
      tick(4);
      serClk = 1'b1;
      tick(4);
    end
    serClk = 1'b0;
    serLoadN = 1'b1;
    tick(10);
  endtask : ser_write

  // field sync, then lines 1 to 4 with three samples each
  task automatic field_step();
    verticalSyncN = 1'b0;
    tick(8);
    verticalSyncN = 1'b1;
    if (pending)
    begin
      seqSlots = newSlots;
      curSlot = 0;
      pending = 0;
    end
    else
      curSlot = (curSlot + 1) % seqSlots.size();
    curField = seqSlots[curSlot];
    tick(12);
    cmp_field(3'(curField));
    for (int ln = 1; ln <= 4; ln++)
    begin
      horizontalSyncN = 1'b0;
      for (int d = 1; d <= 100; d++)
      begin
        tick(1);
        if (d == 8)
          horizontalSyncN = 1'b1;
        if (d % 40 == 15)
          cmp_gates(exp_gates(curField, ln, d - 6));
      end
    end
  endtask : field_step

  // random valid mode word, pending until the next field sync
  task automatic write_mode();
    logic [23:0] m;
    int c;
    c = 1 + rnd(7);
    m = 24'h000000;
    m[23:21] = 3'(c);
    newSlots.delete();
    for (int k = 0; k < 7; k++)
    begin
      m[3 * k +: 3] = 3'(rnd(6));
      if (k < c)
        newSlots.push_back(int'(m[3 * k +: 3]));
    end
    ser_write(`ADDR_SEQ_MODE, m);
    pending = 1;
    cmp_field(3'(curField));
  endtask : write_mode

  task automatic give_verdict();
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : give_verdict

  // ********************************************************************
  // main sequence
  // ********************************************************************
  initial
  begin
    srst = 1'b1;
    horizontalSyncN = 1'b1;
    verticalSyncN = 1'b1;
    serClk = 1'b0;
    serData = 1'b0;
    serLoadN = 1'b1;
    seqSlots.push_back(0);
    tick(20);
    srst = 1'b0;
    tick(4);
    cmp_gates(5'h00);
    cmp_field(3'h0);
    for (int p = 0; p < 4; p++)
    begin
      pT1[p] = 25 + rnd(16);
      pT2[p] = 65 + rnd(16);
      pLvl[p] = rnd(2);
      ser_write(8'(`ADDR_PAT_TOG_BASE + p), {12'(pT2[p]), 12'(pT1[p])});
      ser_write(8'(`ADDR_PAT_LVL_BASE + p), 24'(pLvl[p]));
    end
    for (int f = 0; f < 6; f++)
    begin
      fSel[f] = rnd(1024);
      fMask[f] = rnd(32) & rnd(32);
      fLineA[f] = 1 + rnd(4);
      fLineB[f] = 1 + rnd(5);
      ser_write(8'(`ADDR_FIELD_BASE + 4 * f), 24'(fSel[f]));
      ser_write(8'(`ADDR_FIELD_BASE + 4 * f + 1), 24'(fMask[f]));
      ser_write(8'(`ADDR_FIELD_BASE + 4 * f + 2), 24'(fLineA[f]));
      ser_write(8'(`ADDR_FIELD_BASE + 4 * f + 3), 24'(fLineB[f]));
    end
    // unmapped address must leave every setting alone
    ser_write(8'hff, 24'hffffff);
    field_step();
    field_step();
    for (int r = 0; r < 2; r++)
    begin
      write_mode();
      repeat (2 * newSlots.size() + 1) field_step();
    end
    give_verdict();
  end

  // hang guard
  initial
  begin
    repeat (60000) @(posedge clock);
    n_errors++;
    $display("[FAIL] %0t watchdog expired", $time);
    give_verdict();
  end
endmodule : sensor_gate_field_sequencer_tb
`default_nettype wire

// *** test/vertical_driver_model.sv ***
// Purpose: external vertical driver seen by the sensor gate outputs
// Assumes: driver stage is a plain inverting buffer, no delay
// Notes:   bench checks that the inverted copy matches the model
`timescale 1ns/1ps
`default_nettype none
`include "sg_cfg.svh"

module vertical_driver_model
(
  input wire logic [`GATE_COUNT-1:0] gateIn,
  output logic [`GATE_COUNT-1:0] ccdGate
);
  // driver inverts every gate line toward the sensor
  assign ccdGate = ~gateIn;
endmodule : vertical_driver_model
`default_nettype wire
